// ==== hw/pec_event_counters.sv ====
// Purpose: receive performance event counters of one framer channel
// Assumes: line and framer inputs are same-clock strobes from the receive front end
// Notes: one-second base counted here; shorten SECOND_LEN in simulation
//
// Behaviour
// - AMI counts bipolar violations and runs of sixteen or more zeros.
// - B8ZS counts bipolar violations, code violations and eight empty bit times.
// - HDB3 counts bipolar violations, code violations and four empty bit times.
// - D4 and 96-channel frames count signalling framing errors only when select is set.
// - DDS counts terminal, signalling and channel 24 errors; ESF counts pattern errors.
// - E1 counts alignment word errors, plus non-alignment bit 2 when select is clear.
// - ESF or E1 with CRC counts every failed checksum.
// - Excessive CRC flagged at 320 per second ESF, 915 per second E1 with CRC-4.
// - E1 CRC-4 counts zero far-end bits in frames 13 and 15.
// - Any enabled error in a second makes it errored and counts it.
// - Default errored criterion is one qualifying event chosen by mode and view.
// - T1 bursty second: more than one, below 8 framing or 320 CRC errors.
// - E1 bursty second: more than one, below 16 framing, or below 915 with CRC-4.
// - T1 severe second: 8 framing errors or 320 CRC errors.
// - E1 severe second: 16 framing errors, or 915 events with CRC-4.
// - Each second spent unavailable increments the unavailable second counter.
// - Ten consecutive severe seconds enter the unavailable state.
// - Ten consecutive non-severe seconds leave the unavailable state.
// - Hardwired bursty and severe thresholds apply until host loads replacement values.
// - Error counts are presented as host-readable status counters.
// - Errored and severe second counters hold while unavailable.

`timescale 1ns/1ps

// =====================================================================
// Top
module pec_event_counters
	import pec_pkg::*;
#(
	parameter int SECOND_LEN = SECOND_CYCLES
)
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	// Dual-rail line symbols, one bit time per strobe
	input wire logic RX_BIT_VALID,
	input wire logic RX_POS,
	input wire logic RX_NEG,
	input wire logic RX_SUBST_PULSE,
	input wire logic RX_CODE_VIOL,
	// Framer alignment results, one-cycle strobes
	input wire logic TERMINAL_FRAMING_BIT_ERR,
	input wire logic SIGNALING_FRAMING_BIT_ERR,
	input wire logic DDS_CH24_ERR,
	input wire logic EXTENDED_SUPERFRAME_PATTERN_BIT_ERR,
	input wire logic FAS_WORD_ERR,
	input wire logic NFAS_BIT2_ERR,
	input wire logic CRC_FAIL,
	input wire logic EBIT_VALID,
	input wire logic EBIT_VALUE,
	input wire logic [3:0] MF_FRAME_NUM,
	input wire logic SA6_CODE_VALID,
	input wire logic [3:0] SA6_CODE,
	// Configuration
	input wire logic [1:0] LINE_CODE,
	input wire logic [2:0] FRAME_MODE,
	input wire logic CRC4_ENABLE,
	input wire logic FRAMING_CHECK_SELECT_CONFIG,
	input wire logic [1:0] SECOND_VIEW_SELECT,
	input wire logic [ES_EN_W-1:0] ERRORED_SECOND_ENABLE,
	input wire logic SECOND_THRESHOLD_LOAD,
	input wire logic [SEC_CNT_W-1:0] SECOND_THRESHOLD_BURSTY,
	input wire logic [SEC_CNT_W-1:0] SECOND_THRESHOLD_SEVERE,
	input wire logic COUNTER_CLEAR,
	// Status
	output logic [CNT_W-1:0] BPV_COUNT,
	output logic [CNT_W-1:0] FER_COUNT,
	output logic [CNT_W-1:0] CRC_COUNT,
	output logic [CNT_W-1:0] EBIT_COUNT,
	output logic [CNT_W-1:0] ES_COUNT,
	output logic [CNT_W-1:0] BES_COUNT,
	output logic [CNT_W-1:0] SES_COUNT,
	output logic [CNT_W-1:0] UAS_COUNT,
	output logic EXCESSIVE_CRC,
	output logic UNAVAILABLE,
	output logic SECOND_TICK
);

	// =================================================================
	// Mode decode
	pec_line_code_type line_code;
	pec_frame_mode_type frame_mode;
	pec_view_type view;
	logic is_esf;
	logic is_e1;
	logic is_crc4;
	logic is_t1_sf;

	assign line_code = pec_line_code_type'(LINE_CODE);
	assign frame_mode = pec_frame_mode_type'(FRAME_MODE);
	assign view = pec_view_type'(SECOND_VIEW_SELECT);
	assign is_esf = (frame_mode == FM_ESF);
	assign is_e1 = (frame_mode == FM_E1);
	assign is_crc4 = is_e1 && CRC4_ENABLE;
	assign is_t1_sf = !is_esf && !is_e1;

	// =================================================================
	// Bipolar and code violations
	// Dual-rail input is what makes polarity visible at all here.
	logic pulse;
	logic pulse_pol;
	logic last_pol_reg;
	logic [RUN_W-1:0] zero_run_reg;
	logic [RUN_W-1:0] zero_limit;
	logic bpv_raw;
	logic cv_raw;
	logic zero_hit;
	logic bpv_event;

	assign pulse = RX_POS ^ RX_NEG;
	assign pulse_pol = RX_POS;
	assign bpv_raw = RX_BIT_VALID && pulse && (pulse_pol == last_pol_reg);
	assign cv_raw = RX_BIT_VALID && ((RX_POS && RX_NEG) || RX_CODE_VIOL);

	always_comb
	begin
		case (line_code)
			LC_AMI: zero_limit = ZERO_RUN_AMI;
			LC_B8ZS: zero_limit = ZERO_RUN_B8ZS;
			LC_HDB3: zero_limit = ZERO_RUN_HDB3;
			default: zero_limit = ZERO_RUN_AMI;
		endcase
	end

	// Event fires once per run, on the bit that reaches the limit
	assign zero_hit = RX_BIT_VALID && !RX_POS && !RX_NEG
		&& (zero_run_reg == zero_limit - RUN_W'(1));

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			last_pol_reg <= 1'b0;
		else if (RX_BIT_VALID && pulse)
			last_pol_reg <= pulse_pol;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			zero_run_reg <= '0;
		else if (RX_BIT_VALID)
		begin
			if (RX_POS || RX_NEG)
				zero_run_reg <= '0;
			else if (zero_run_reg != '1)
				zero_run_reg <= zero_run_reg + RUN_W'(1);
		end
	end

	always_comb
	begin
		case (line_code)
			LC_AMI: bpv_event = bpv_raw || zero_hit;
			LC_B8ZS, LC_HDB3: bpv_event = (bpv_raw && !RX_SUBST_PULSE) || cv_raw || zero_hit;
			default: bpv_event = 1'b0;
		endcase
	end

	// =================================================================
	// Framing, CRC and far-end events
	logic fer_event;
	logic crc_event;
	logic ebit_event;
	logic nt1_event;
	logic nt1_remote_event;

	always_comb
	begin
		case (frame_mode)
			FM_SF_D4, FM_SF_96CH: fer_event = TERMINAL_FRAMING_BIT_ERR
				|| (FRAMING_CHECK_SELECT_CONFIG && SIGNALING_FRAMING_BIT_ERR);
			FM_SF_DDS: fer_event = TERMINAL_FRAMING_BIT_ERR
				|| SIGNALING_FRAMING_BIT_ERR || DDS_CH24_ERR;
			FM_ESF: fer_event = EXTENDED_SUPERFRAME_PATTERN_BIT_ERR;
			FM_E1: fer_event = FAS_WORD_ERR
				|| (!FRAMING_CHECK_SELECT_CONFIG && NFAS_BIT2_ERR);
			default: fer_event = 1'b0;
		endcase
	end

	assign crc_event = (is_esf || is_crc4) && CRC_FAIL;
	assign ebit_event = is_crc4 && EBIT_VALID && !EBIT_VALUE
		&& (MF_FRAME_NUM == EBIT_FRAME_A || MF_FRAME_NUM == EBIT_FRAME_B);
	assign nt1_event = is_crc4 && SA6_CODE_VALID && (SA6_CODE[3:1] == 3'h1);
	assign nt1_remote_event = is_crc4 && SA6_CODE_VALID
		&& !SA6_CODE[3] && !SA6_CODE[2] && SA6_CODE[0];

	// =================================================================
	// One-second base
	logic [31:0] tick_cnt_reg;
	logic tick;

	assign tick = (tick_cnt_reg == 32'(SECOND_LEN - 1));

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			tick_cnt_reg <= '0;
		else if (tick)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
	end

	// =================================================================
	// Per-second accumulation
	logic qual_event;
	logic [SEC_CNT_W-1:0] qual_cnt_reg;
	logic [SEC_CNT_W-1:0] crc_sec_reg;
	logic [ES_EN_W-1:0] seen_reg;
	logic [ES_EN_W-1:0] seen_now;

	always_comb
	begin
		if (is_crc4)
		begin
			case (view)
				VW_LOCAL: qual_event = crc_event;
				VW_REMOTE: qual_event = ebit_event;
				VW_NT1: qual_event = nt1_event;
				VW_NT1_REMOTE: qual_event = nt1_remote_event;
				default: qual_event = 1'b0;
			endcase
		end
		else if (is_esf)
			qual_event = crc_event;
		else
			qual_event = fer_event;
	end

	assign seen_now = {bpv_event, nt1_remote_event, nt1_event, ebit_event, crc_event, fer_event};

	// Events in the tick cycle open the next second, so none is dropped
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			seen_reg <= '0;
		else if (tick)
			seen_reg <= seen_now;
		else
			seen_reg <= seen_reg | seen_now;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			qual_cnt_reg <= '0;
		else if (tick)
			qual_cnt_reg <= {{(SEC_CNT_W-1){1'b0}}, qual_event};
		else if (qual_event && qual_cnt_reg != '1)
			qual_cnt_reg <= qual_cnt_reg + SEC_CNT_W'(1);
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			crc_sec_reg <= '0;
		else if (tick)
			crc_sec_reg <= {{(SEC_CNT_W-1){1'b0}}, crc_event};
		else if (crc_event && crc_sec_reg != '1)
			crc_sec_reg <= crc_sec_reg + SEC_CNT_W'(1);
	end

	// =================================================================
	// Thresholds
	// Host values replace the bursty and severe defaults at once, not the excessive CRC marks; only reset restores them.
	logic thr_loaded_reg;
	logic [SEC_CNT_W-1:0] thr_bes_reg;
	logic [SEC_CNT_W-1:0] thr_ses_reg;
	logic [SEC_CNT_W-1:0] bes_low;
	logic [SEC_CNT_W-1:0] ses_thr;
	logic [SEC_CNT_W-1:0] xcrc_thr;

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			thr_loaded_reg <= 1'b0;
			thr_bes_reg <= BES_LOW_DEFAULT;
			thr_ses_reg <= SES_SF_DEFAULT;
		end
		else if (SECOND_THRESHOLD_LOAD)
		begin
			thr_loaded_reg <= 1'b1;
			thr_bes_reg <= SECOND_THRESHOLD_BURSTY;
			thr_ses_reg <= SECOND_THRESHOLD_SEVERE;
		end
	end

	always_comb
	begin
		bes_low = thr_loaded_reg ? thr_bes_reg : BES_LOW_DEFAULT;
		if (thr_loaded_reg)
			ses_thr = thr_ses_reg;
		else if (is_crc4)
			ses_thr = SES_CRC4_DEFAULT;
		else if (is_e1)
			ses_thr = SES_E1_DEFAULT;
		else if (is_esf)
			ses_thr = SES_ESF_DEFAULT;
		else
			ses_thr = SES_SF_DEFAULT;
		xcrc_thr = is_esf ? XCRC_ESF : XCRC_CRC4;
	end

	// =================================================================
	// Second classification
	logic sec_errored;
	logic sec_bursty;
	logic sec_severe;

	assign sec_errored = (qual_cnt_reg != '0) || ((seen_reg & ERRORED_SECOND_ENABLE) != '0);
	assign sec_bursty = (qual_cnt_reg > bes_low) && (qual_cnt_reg < ses_thr);
	assign sec_severe = (qual_cnt_reg >= ses_thr);

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			EXCESSIVE_CRC <= 1'b0;
		else if (tick)
			EXCESSIVE_CRC <= (is_esf || is_crc4) && (crc_sec_reg >= xcrc_thr);
	end

	// =================================================================
	// Unavailable state
	logic [3:0] run_reg;
	logic unavail_reg;

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			run_reg <= '0;
			unavail_reg <= 1'b0;
		end
		else if (tick)
		begin
			// Run counts the seconds that would flip the state
			if (sec_severe != unavail_reg)
			begin
				if (run_reg == UAS_RUN - 4'h1)
				begin
					run_reg <= '0;
					unavail_reg <= !unavail_reg;
				end
				else
					run_reg <= run_reg + 4'h1;
			end
			else
				run_reg <= '0;
		end
	end

	assign UNAVAILABLE = unavail_reg;

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			SECOND_TICK <= 1'b0;
		else
			SECOND_TICK <= tick;
	end

	// =================================================================
	// Status counter bank
	logic [NUM_CNT-1:0] inc_vec;
	logic [CNT_W-1:0] count_arr [NUM_CNT];
	logic uas_inc;

	assign inc_vec[IDX_BPV] = bpv_event;
	assign inc_vec[IDX_FER] = fer_event;
	assign inc_vec[IDX_CRC] = crc_event;
	assign inc_vec[IDX_EBIT] = ebit_event;
	assign inc_vec[IDX_ES] = tick && !unavail_reg && sec_errored;
	assign inc_vec[IDX_BES] = tick && !unavail_reg && sec_bursty;
	assign inc_vec[IDX_SES] = tick && !unavail_reg && sec_severe;
	assign uas_inc = tick && unavail_reg;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CNT; gi++)
		begin : g_cnt
			pec_sat_counter u_cnt (
				.clk(CLK_SYS),
				.rst(SYS_RST),
				.inc(inc_vec[gi]),
				.clr(COUNTER_CLEAR),
				.count(count_arr[gi])
			);
		end
	endgenerate

	pec_sat_counter u_uas (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.inc(uas_inc),
		.clr(COUNTER_CLEAR),
		.count(UAS_COUNT)
	);

	// Host reads these directly
	assign BPV_COUNT = count_arr[IDX_BPV];
	assign FER_COUNT = count_arr[IDX_FER];
	assign CRC_COUNT = count_arr[IDX_CRC];
	assign EBIT_COUNT = count_arr[IDX_EBIT];
	assign ES_COUNT = count_arr[IDX_ES];
	assign BES_COUNT = count_arr[IDX_BES];
	assign SES_COUNT = count_arr[IDX_SES];

endmodule : pec_event_counters

// ==== hw/pec_pkg.sv ====
// Purpose: constants and types for the receive performance event counters
// Assumes: one receive framer channel, 100 MHz system clock
// Notes: all figures used by the counter block live here

// =====================================================================
// Package
package pec_pkg;

	// =================================================================
	// Clock and timing base
	localparam int CLK_PERIOD_NS = 10;
	localparam int SECOND_NS = 1000000000;
	localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

	// =================================================================
	// Widths
	localparam int CNT_W = 16;
	localparam int SEC_CNT_W = 10;
	localparam int RUN_W = 5;
	localparam int NUM_CNT = 7;
	localparam int ES_EN_W = 6;

	// =================================================================
	// Counter index in the status bank
	localparam int IDX_BPV = 0;
	localparam int IDX_FER = 1;
	localparam int IDX_CRC = 2;
	localparam int IDX_EBIT = 3;
	localparam int IDX_ES = 4;
	localparam int IDX_BES = 5;
	localparam int IDX_SES = 6;

	// =================================================================
	// Errored second enable bit positions
	localparam int ESEN_FRAMING = 0;
	localparam int ESEN_CRC = 1;
	localparam int ESEN_EBIT = 2;
	localparam int ESEN_NT1 = 3;
	localparam int ESEN_NT1_REMOTE = 4;
	localparam int ESEN_BPV = 5;

	// =================================================================
	// Line code thresholds, consecutive empty bit times
	localparam logic [RUN_W-1:0] ZERO_RUN_AMI = 5'h10;
	localparam logic [RUN_W-1:0] ZERO_RUN_B8ZS = 5'h08;
	localparam logic [RUN_W-1:0] ZERO_RUN_HDB3 = 5'h04;

	// =================================================================
	// Per-second thresholds
	localparam logic [SEC_CNT_W-1:0] BES_LOW_DEFAULT = 10'h001;
	localparam logic [SEC_CNT_W-1:0] SES_SF_DEFAULT = 10'h008;
	localparam logic [SEC_CNT_W-1:0] SES_ESF_DEFAULT = 10'h140;
	localparam logic [SEC_CNT_W-1:0] SES_E1_DEFAULT = 10'h010;
	localparam logic [SEC_CNT_W-1:0] SES_CRC4_DEFAULT = 10'h393;
	localparam logic [SEC_CNT_W-1:0] XCRC_ESF = 10'h140;
	localparam logic [SEC_CNT_W-1:0] XCRC_CRC4 = 10'h393;
	localparam logic [3:0] UAS_RUN = 4'ha;

	// =================================================================
	// Multiframe positions holding far-end error bits
	localparam logic [3:0] EBIT_FRAME_A = 4'hd;
	localparam logic [3:0] EBIT_FRAME_B = 4'hf;

	// =================================================================
	// Modes
	typedef enum logic [1:0] {LC_AMI, LC_B8ZS, LC_HDB3, LC_RSVD} pec_line_code_type;
	typedef enum logic [2:0] {FM_SF_D4, FM_SF_96CH, FM_SF_DDS, FM_ESF, FM_E1}
		pec_frame_mode_type;
	typedef enum logic [1:0] {VW_LOCAL, VW_REMOTE, VW_NT1, VW_NT1_REMOTE} pec_view_type;

endpackage : pec_pkg

// ==== hw/pec_sat_counter.sv ====
// Purpose: 16-bit event counter that sticks at full scale
// Assumes: increment and clear are single-cycle pulses
// Notes: a clear in the same cycle as an event keeps that event

`timescale 1ns/1ps

// =====================================================================
// Saturating counter
module pec_sat_counter
	import pec_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic inc,
	input wire logic clr,
	// Count
	output logic [CNT_W-1:0] count
);

	logic [CNT_W-1:0] count_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
			count_reg <= '0;
		else if (clr)
			count_reg <= inc ? CNT_W'(1) : '0;
		else if (inc && count_reg != '1)
			count_reg <= count_reg + CNT_W'(1);
	end

	assign count = count_reg;

endmodule : pec_sat_counter

// ==== tb/pec_event_counters_sva.sv ====
// Purpose: port assertions for the receive performance event counters
// Assumes: one clock, synchronous active-high reset
// Notes: tick spacing is judged only after a first tick, so reset needs no guess

`timescale 1ns/1ps

// ==========================
// Checker
module pec_event_counters_sva
	import pec_pkg::*;
#(
	parameter int SECOND_LEN = SECOND_CYCLES
)
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	// Causes
	input wire logic CRC_FAIL,
	input wire logic EBIT_VALID,
	input wire logic EBIT_VALUE,
	input wire logic [3:0] MF_FRAME_NUM,
	input wire logic [2:0] FRAME_MODE,
	input wire logic CRC4_ENABLE,
	input wire logic COUNTER_CLEAR,
	// Results
	input wire logic [CNT_W-1:0] CRC_COUNT,
	input wire logic [CNT_W-1:0] EBIT_COUNT,
	input wire logic [CNT_W-1:0] ES_COUNT,
	input wire logic [CNT_W-1:0] SES_COUNT,
	input wire logic [CNT_W-1:0] UAS_COUNT,
	input wire logic UNAVAILABLE,
	input wire logic SECOND_TICK
);
	default clocking dc @(posedge CLK_SYS);
	endclocking
	default disable iff (SYS_RST);
	int gap_reg;
	logic seen_reg;

	// Cycles since the last tick
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			gap_reg <= 0;
			seen_reg <= 1'b0;
		end
		else if (SECOND_TICK)
		begin
			gap_reg <= 1;
			seen_reg <= 1'b1;
		end
		else
			gap_reg <= gap_reg + 1;
	end

	a_tick_spacing: assert property (SECOND_TICK && seen_reg |-> gap_reg == SECOND_LEN)
		else $error("second tick spacing wrong");
	a_crc_increment: assert property (CRC_FAIL && FRAME_MODE == 3'h3 && !COUNTER_CLEAR
		&& CRC_COUNT != 16'hffff |=> CRC_COUNT == $past(CRC_COUNT) + 16'h1)
		else $error("checksum failure not counted");
	a_crc_idle: assert property (!CRC_FAIL && !COUNTER_CLEAR |=> $stable(CRC_COUNT))
		else $error("checksum count moved without cause");
	a_crc_saturate: assert property (CRC_COUNT == 16'hffff && !COUNTER_CLEAR
		|=> CRC_COUNT == 16'hffff)
		else $error("checksum count wrapped");
	a_ebit_frames: assert property (EBIT_VALID && !EBIT_VALUE && FRAME_MODE == 3'h4
		&& CRC4_ENABLE && (MF_FRAME_NUM == 4'hd || MF_FRAME_NUM == 4'hf) && !COUNTER_CLEAR
		&& EBIT_COUNT != 16'hffff |=> EBIT_COUNT == $past(EBIT_COUNT) + 16'h1)
		else $error("far-end error bit not counted");
	a_unav_holds: assert property (UNAVAILABLE && !COUNTER_CLEAR
		|=> $stable(ES_COUNT) && $stable(SES_COUNT))
		else $error("second counts moved while unavailable");
	a_uas_counts: assert property (SECOND_TICK && $past(UNAVAILABLE) && !$past(COUNTER_CLEAR)
		&& $past(UAS_COUNT) != 16'hffff |-> UAS_COUNT == $past(UAS_COUNT) + 16'h1)
		else $error("unavailable second not counted");
	a_unav_enter: assert property ($rose(UNAVAILABLE)
		|-> SECOND_TICK && SES_COUNT != $past(SES_COUNT))
		else $error("unavailable entered off a severe tick");
	a_unav_leave: assert property ($fell(UNAVAILABLE)
		|-> SECOND_TICK && $stable(SES_COUNT) && UAS_COUNT != $past(UAS_COUNT))
		else $error("unavailable left off a clean tick");
	a_es_on_tick: assert property ($changed(ES_COUNT)
		|-> SECOND_TICK || $past(COUNTER_CLEAR))
		else $error("errored second count moved between ticks");
	a_count_clear: assert property (COUNTER_CLEAR && !CRC_FAIL |=> CRC_COUNT == 16'h0)
		else $error("clear did not zero checksum count");
endmodule : pec_event_counters_sva

bind pec_event_counters pec_event_counters_sva #(.SECOND_LEN(SECOND_LEN)) u_sva (.CLK_SYS,
	.SYS_RST, .CRC_FAIL, .EBIT_VALID, .EBIT_VALUE, .MF_FRAME_NUM, .FRAME_MODE, .CRC4_ENABLE,
	.COUNTER_CLEAR, .CRC_COUNT, .EBIT_COUNT, .ES_COUNT, .SES_COUNT, .UAS_COUNT, .UNAVAILABLE,
	.SECOND_TICK);

// ==== tb/pec_event_counters_tb.sv ====
// Purpose: self-checking bench for the receive performance event counters
// Assumes: second shortened to 50 cycles, integer model of every counter
// Notes: one long checksum run reaches full scale on purpose

`timescale 1ns/1ps

`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s exp %0h got %0h", n, e, g); end end

// ==========================
// Bench
module pec_event_counters_tb;
	import pec_pkg::*;
	logic clk = 1'b0, rst = 1'b1, clr = 1'b0, thl = 1'b0, crc4 = 1'b0, fsel = 1'b0;
	logic evv = 1'b0, sv = 1'b0, bv, bp, bn, bs, bc, tick, xcrc, unav;
	logic [7:0] fr = 8'h00;
	logic [5:0] ese = 6'h00;
	logic [3:0] mf = 4'h0, sa6 = 4'h0;
	logic [2:0] fm = 3'h0;
	logic [1:0] lc = 2'h0, vw = 2'h0;
	logic [9:0] thb = 10'h000, ths = 10'h000;
	logic [31:0] rs = 32'hb773d79c;
	logic [15:0] cnt [8];
	int m [8];
	int bad_count = 0, n_checks = 0, lp = 0, zr = 0, un = 0, run = 0, bl = 1, sl = 8, np = 0;
	int secs [$] = '{0, 1, 2, 7, 8, 8, 8, 8, 8, 8, 8, 8, 8, 8, 8, 8, 0, 0, 0, 0, 0, 0, 0, 0,
		0, 0, 1, 4, 0};

	pec_line_unit lu (.clk(clk), .valid(bv), .pos(bp), .neg(bn), .subst(bs), .cviol(bc));

	pec_event_counters #(.SECOND_LEN(50)) DUT (.CLK_SYS(clk), .SYS_RST(rst),
		.RX_BIT_VALID(bv), .RX_POS(bp), .RX_NEG(bn), .RX_SUBST_PULSE(bs), .RX_CODE_VIOL(bc),
		.TERMINAL_FRAMING_BIT_ERR(fr[0]), .SIGNALING_FRAMING_BIT_ERR(fr[1]),
		.DDS_CH24_ERR(fr[2]), .EXTENDED_SUPERFRAME_PATTERN_BIT_ERR(fr[3]),
		.FAS_WORD_ERR(fr[4]), .NFAS_BIT2_ERR(fr[5]), .CRC_FAIL(fr[6]), .EBIT_VALID(fr[7]),
		.EBIT_VALUE(evv), .MF_FRAME_NUM(mf), .SA6_CODE_VALID(sv), .SA6_CODE(sa6),
		.LINE_CODE(lc), .FRAME_MODE(fm), .CRC4_ENABLE(crc4), .FRAMING_CHECK_SELECT_CONFIG(fsel),
		.SECOND_VIEW_SELECT(vw), .ERRORED_SECOND_ENABLE(ese), .SECOND_THRESHOLD_LOAD(thl),
		.SECOND_THRESHOLD_BURSTY(thb), .SECOND_THRESHOLD_SEVERE(ths), .COUNTER_CLEAR(clr),
		.BPV_COUNT(cnt[0]), .FER_COUNT(cnt[1]), .CRC_COUNT(cnt[2]), .EBIT_COUNT(cnt[3]),
		.ES_COUNT(cnt[4]), .BES_COUNT(cnt[5]), .SES_COUNT(cnt[6]), .UAS_COUNT(cnt[7]),
		.EXCESSIVE_CRC(xcrc), .UNAVAILABLE(unav), .SECOND_TICK(tick));

	initial
	begin
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs

	// Which framing strobe counts in which mode
	function automatic int fhit(input int md, input int s, input int i);
		case (md)
			0, 1: return i == 0 || (i == 1 && s == 1);
			2: return i < 3;
			3: return i == 3;
			4: return i == 4 || (i == 5 && s == 0);
			default: return 0;
		endcase
	endfunction : fhit

	task automatic check(input int n);
		for (int i = 0; i < n; i++)
			`CHK($sformatf("count %0d", i), m[i], cnt[i])
	endtask : check

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	// One strobe with random side inputs, then a quiet cycle
	task automatic pulse(input int i);
		fr[i] = 1'b1;
		{sv, sa6, vw, ese} = rs[12:0];
		rs = xs(rs);
		@(posedge clk);
		#1;
		fr = 8'h00;
		sv = 1'b0;
		@(posedge clk);
		#1;
	endtask : pulse

	// Line symbol: k 0/1 empty, 2 alternating pulse, 3 repeated polarity
	task automatic sym(input int k, input logic s, input logic c);
		int thr;
		logic p;
		thr = (lc == 2'h0) ? 16 : (lc == 2'h1) ? 8 : 4;
		p = (k == 2) ? !lp[0] : lp[0];
		if (k < 2)
		begin
			lu.send(1'b0, 1'b0, 1'b0, 1'b0, rs[4] ? 2 : 0);
			zr++;
			m[0] += (lc != 2'h3 && zr == thr);
		end
		else
		begin
			lu.send(p, !p, s, c, rs[4] ? 2 : 0);
			m[0] += (lc != 2'h3 && ((p == lp[0] && !s) || c));
			lp = p;
			zr = 0;
		end
	endtask : sym

	task automatic wait_tick;
		int g;
		g = 0;
		do
		begin
			@(posedge clk);
			#1;
			g++;
		end while (tick !== 1'b1 && g < 200);
		`CHK("tick", 1, tick)
	endtask : wait_tick

	initial
	begin
		#1000000;
		bad_count++;
		wrap_up();
	end

	initial
	begin
		m = '{default: 0};
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		check(8);
		for (int c = 0; c < 4; c++)
		begin
			lc = c[1:0];
			for (int j = 0; j < 60; j++)
			begin
				sym(rs[1:0], rs[2] && c > 0 && c < 3, rs[3] && c > 0 && c < 3);
				rs = xs(rs);
			end
			repeat (17) sym(0, 1'b0, 1'b0);
			sym(2, 1'b0, 1'b0);
			`CHK("bpv", m[0], cnt[0])
		end
		for (int md = 0; md < 6; md++)
			for (int s = 0; s < 2; s++)
				for (int i = 0; i < 6; i++)
				begin
					fm = md[2:0];
					fsel = s[0];
					pulse(i);
					m[1] += fhit(md, s, i);
					`CHK("fer", m[1], cnt[1])
				end
		for (int md = 0; md < 5; md++)
			for (int c4 = 0; c4 < 2; c4++)
			begin
				fm = md[2:0];
				crc4 = c4[0];
				pulse(6);
				m[2] += (md == 3 || (md == 4 && c4 == 1));
				`CHK("crc", m[2], cnt[2])
			end
		fm = 3'h4;
		for (int c4 = 0; c4 < 2; c4++)
			for (int f = 12; f < 16; f++)
				for (int v = 0; v < 2; v++)
				begin
					crc4 = c4[0];
					mf = f[3:0];
					evv = v[0];
					pulse(7);
					m[3] += (c4 == 1 && v == 0 && (f == 13 || f == 15));
					`CHK("ebit", m[3], cnt[3])
				end
		clr = 1'b1;
		@(posedge clk);
		#1;
		clr = 1'b0;
		m = '{default: 0};
		check(4);
		// Full-scale run: 50 failures per second stay below the excessive mark
		fm = 3'h3;
		fr[6] = 1'b1;
		repeat (65540) @(posedge clk);
		#1;
		fr[6] = 1'b0;
		`CHK("crc", 65535, cnt[2])
		`CHK("xcrc", 0, xcrc)
		rst = 1'b1;
		{fm, fsel, crc4, ese, vw} = '0;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		m = '{default: 0};
		check(8);
		foreach (secs[k])
		begin
			wait_tick();
			if (un == 1)
				m[7]++;
			else
			begin
				m[4] += (np > 0);
				m[5] += (np > bl && np < sl);
				m[6] += (np >= sl);
			end
			run = ((np >= sl) != un) ? run + 1 : 0;
			if (run == 10)
			begin
				un = !un;
				run = 0;
			end
			check(8);
			`CHK("unav", un, unav)
			if (k == 26)
			begin
				thb = 10'h000;
				ths = 10'h004;
				thl = 1'b1;
				@(posedge clk);
				#1;
				thl = 1'b0;
				bl = 0;
				sl = 4;
			end
			if (secs[k] > 0)
			begin
				fr[0] = 1'b1;
				repeat (secs[k]) @(posedge clk);
				#1;
				fr[0] = 1'b0;
			end
			m[1] += secs[k];
			np = secs[k];
		end
		wait_tick();
		m[4] += (np > 0);
		m[6] += (np >= sl);
		check(8);
		// Enabled cause outside the mode's criterion still marks the second
		fm = 3'h3;
		ese = 6'h01;
		fr[3] = 1'b1;
		@(posedge clk);
		#1;
		fr[3] = 1'b0;
		wait_tick();
		m[1]++;
		m[4]++;
		check(8);
		// Remote view qualifies on far-end bits alone
		{fm, crc4, vw, ese, mf, evv} = {3'h4, 1'b1, 2'h1, 6'h00, 4'hd, 1'b0};
		fr[7] = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		fr[7] = 1'b0;
		wait_tick();
		m[3] += 2;
		m[4]++;
		m[5]++;
		check(8);
		wrap_up();
	end
endmodule : pec_event_counters_tb

// ==== tb/pec_line_unit.sv ====
// Purpose: line interface model sending dual-rail receive symbols
// Assumes: send is entered just after a rising edge
// Notes: idle rails toggle so a stale symbol never looks valid

`timescale 1ns/1ps

// ==========================
// Line interface unit model
module pec_line_unit
(
	// Clock
	input wire logic clk,
	// Dual-rail symbols
	output logic valid,
	output logic pos,
	output logic neg,
	output logic subst,
	output logic cviol
);
	initial
	begin
		valid = 1'b0;
		pos = 1'b0;
		neg = 1'b1;
		subst = 1'b0;
		cviol = 1'b0;
	end

	// One bit time, then at least one idle cycle
	task automatic send(input logic p, input logic n, input logic s, input logic c, input int gap);
		valid <= 1'b1;
		pos <= p;
		neg <= n;
		subst <= s;
		cviol <= c;
		@(posedge clk);
		#1;
		valid <= 1'b0;
		subst <= 1'b0;
		cviol <= 1'b0;
		pos <= !p;
		neg <= !n;
		@(posedge clk);
		#1;
		// Rails left alone at the end, so the next bit sets them only once
		repeat (gap)
		begin
			pos <= !pos;
			neg <= !neg;
			@(posedge clk);
			#1;
		end
	endtask : send
endmodule : pec_line_unit
